// [hdl/port_config_lock_and_altfunc.sv]
// Port configuration lock and alternate function select, AXI4-Lite slave
// How it works
// RL1 - Software writes key 1, 0, 1 with pattern
// RL2 - Key reads 1 after correct sequence
// RL3 - Changed pattern or wrong order aborts lock
// RL4 - Lock holds until system or peripheral reset
// RL5 - Key readable always, set only by sequence
// RL6 - Key reads 1 after first lock
// RL7 - Pin lock bits writable only while unlocked
// RL8 - Pin lock bit 1 marks pin locked
// RL9 - Four-bit selector per pin, pins 0-7
// RL10 - Function select at 0x20, resets zero
// RL11 - Locked pin ignores configuration writes
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module port_config_lock_and_altfunc (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic periph_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [15:0] pin_lock_o,
  output logic lock_key_o,
  output logic [31:0] pin_function_select_low_o
);
  import port_lock_pkg::*;

  // Bus, key and lock state in one record; the selectors live in pin_field_gate
  typedef struct packed {
    logic aw_held; // Write address captured
    logic [7:0] aw_addr; // Captured write address
    logic w_held; // Write data captured
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb; // Captured byte strobes
    logic bvalid; // Write answer pending
    logic [1:0] bresp; // Write answer code
    logic rvalid; // Read answer pending
    logic [31:0] rdata; // Read answer data
    logic [1:0] rresp; // Read answer code
    key_state_t key_state; // Lock sequence progress
    logic [15:0] key_pattern; // Pattern of the first key write
    logic [15:0] pin_locks; // Per-pin lock bits
  } state_t;

  state_t cur; // Registered state
  state_t next_cur; // Next state
  logic do_write; // Both halves of a write present
  logic lock_wr; // Write to the lock register
  logic func_wr; // Write to the function select register
  logic key_active; // Lock engaged
  logic [31:0] func_word; // Assembled selectors
  logic [31:0] lock_word; // Lock register image

  assign key_active = (cur.key_state == KEY_DONE);
  assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
  assign lock_wr = do_write && (cur.aw_addr[7:2] == OFFS_LOCK[7:2]);
  assign func_wr = do_write && (cur.aw_addr[7:2] == OFFS_FUNC_LOW[7:2]); // [RL10]
  // Key bit reads live state; pin lock bits sit in the low half
  assign lock_word = {15'h0000, key_active, cur.pin_locks}; // [RL2] [RL5] [RL6]

  // One gated selector for each of pins 0 to 7; a locked pin drops writes to its field
  for (genvar g = 0; g < FUNC_PINS; g++) begin : g_sel
    pin_field_gate u_sel (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .clr_i(periph_rst_i), // [RL4]
      .wr_i(func_wr),
      .strb_mask_i({4{cur.w_strb[g/2]}}),
      .locked_i(key_active && cur.pin_locks[g]), // [RL8] [RL11]
      .wdata_i(cur.w_data[FUNC_WIDTH*g +: FUNC_WIDTH]), // [RL9]
      .sel_o(func_word[FUNC_WIDTH*g +: FUNC_WIDTH])
    );
  end

  // Bus handshake, key sequence and lock bits
  always_comb begin
    next_cur = cur;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid_i && !cur.aw_held) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !cur.w_held) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata_i;
      next_cur.w_strb = s_axi_wstrb_i;
    end
    if (do_write) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = (lock_wr || func_wr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (cur.bvalid && s_axi_bready_i) begin
      next_cur.bvalid = 1'b0;
    end
    // Lock register writes use the whole word; partial strobes still count
    if (lock_wr && !key_active) begin
      next_cur.pin_locks = cur.w_data[15:0]; // [RL7]
      case (cur.key_state)
        KEY_IDLE: begin
          if (cur.w_data[LOCK_KEY_POS]) begin // [RL1]
            next_cur.key_state = KEY_SEEN1;
            next_cur.key_pattern = cur.w_data[15:0];
          end
        end
        KEY_SEEN1: begin
          // Wrong key or changed pattern restarts the sequence
          if (!cur.w_data[LOCK_KEY_POS] && cur.w_data[15:0] == cur.key_pattern) begin // [RL3]
            next_cur.key_state = KEY_SEEN0;
          end else begin
            next_cur.key_state = cur.w_data[LOCK_KEY_POS] ? KEY_SEEN1 : KEY_IDLE; // [RL3]
            next_cur.key_pattern = cur.w_data[15:0];
          end
        end
        KEY_SEEN0: begin
          if (cur.w_data[LOCK_KEY_POS] && cur.w_data[15:0] == cur.key_pattern) begin
            next_cur.key_state = KEY_DONE; // [RL1]
          end else begin
            next_cur.key_state = cur.w_data[LOCK_KEY_POS] ? KEY_SEEN1 : KEY_IDLE; // [RL3]
            next_cur.key_pattern = cur.w_data[15:0];
          end
        end
        default: begin
          next_cur.key_state = KEY_IDLE;
        end
      endcase
    end
    // Read channel: one read at a time, answered the cycle after
    if (s_axi_arvalid_i && !cur.rvalid) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      if (s_axi_araddr_i[7:2] == OFFS_LOCK[7:2]) begin
        next_cur.rdata = lock_word; // [RL2]
      end else if (s_axi_araddr_i[7:2] == OFFS_FUNC_LOW[7:2]) begin
        next_cur.rdata = func_word;
      end else begin
        next_cur.rdata = 32'h0000_0000;
        next_cur.rresp = RESP_SLVERR;
      end
    end else if (cur.rvalid && s_axi_rready_i) begin
      next_cur.rvalid = 1'b0;
    end
  end

  // State register; peripheral reset clears like system reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0; // [RL4]
    end else if (ce_i) begin
      if (periph_rst_i) begin
        cur <= '0; // [RL4]
      end else begin
        cur <= next_cur;
      end
    end
  end

  assign s_axi_awready_o = !cur.aw_held;
  assign s_axi_wready_o = !cur.w_held;
  assign s_axi_bvalid_o = cur.bvalid;
  assign s_axi_bresp_o = cur.bresp;
  assign s_axi_arready_o = !cur.rvalid;
  assign s_axi_rvalid_o = cur.rvalid;
  assign s_axi_rdata_o = cur.rdata;
  assign s_axi_rresp_o = cur.rresp;
  assign pin_lock_o = cur.pin_locks;
  assign lock_key_o = key_active;
  assign pin_function_select_low_o = func_word;

  // Assertions
  sequence s_key_one;
    lock_wr && cur.w_data[LOCK_KEY_POS];
  endsequence

  a_lock_sticks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL4]
    key_active && !periph_rst_i && ce_i |=> key_active)
    else $error("lock dropped without reset");
  a_key_read_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL6]
    ce_i && !periph_rst_i && key_active && s_axi_arvalid_i && !cur.rvalid
      && s_axi_araddr_i[7:2] == OFFS_LOCK[7:2] |=> s_axi_rdata_o[LOCK_KEY_POS])
    else $error("key bit read zero while locked");
  a_locks_frozen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL7]
    key_active && !periph_rst_i && ce_i |=> $stable(pin_lock_o))
    else $error("pin locks changed while locked");
  a_key_only_seq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL5]
    !key_active && !(ce_i && cur.key_state == KEY_SEEN0 && lock_wr && cur.w_data[LOCK_KEY_POS]) |=> !key_active)
    else $error("key set outside sequence");
  a_abort_change: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL3]
    ce_i && !periph_rst_i && cur.key_state == KEY_SEEN0 && lock_wr
      && cur.w_data[15:0] != cur.key_pattern |=> !key_active)
    else $error("lock engaged with changed pattern");
  a_seq_engages: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL2]
    (ce_i && !periph_rst_i && cur.key_state == KEY_SEEN0 && cur.w_data[15:0] == cur.key_pattern)
      ##0 s_key_one |=> key_active ##0 lock_word[LOCK_KEY_POS])
    else $error("correct sequence did not lock");
  a_func_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL11]
    ce_i && !periph_rst_i && key_active && cur.pin_locks[0] |=> $stable(pin_function_select_low_o[3:0]))
    else $error("locked pin selector changed");
  a_func_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL9]
    ce_i && !periph_rst_i && func_wr && !key_active && cur.w_strb[0]
      |=> pin_function_select_low_o[3:0] == $past(cur.w_data[3:0]))
    else $error("selector write not stored");
  a_write_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL10]
    ce_i && !periph_rst_i && func_wr |=> s_axi_bvalid_o && s_axi_bresp_o == RESP_OKAY)
    else $error("function register write not answered okay");
endmodule

// [hdl/port_lock_pkg.sv]
// Register map, field layout and reset values of the port lock and function select block
package port_lock_pkg;
  localparam logic [7:0] OFFS_LOCK = 8'h1c; // Port lock register
  localparam logic [7:0] OFFS_FUNC_LOW = 8'h20; // Function select, pins 0 to 7
  localparam int LOCK_KEY_POS = 16; // Key bit position
  localparam int PIN_COUNT = 16; // Pins in the port
  localparam int FUNC_PINS = 8; // Pins in the low select register
  localparam int FUNC_WIDTH = 4; // Bits per selector
  localparam logic [31:0] FUNC_LOW_RESET = 32'h0000_0000; // All pins on function 0
  localparam logic [15:0] PIN_LOCK_RESET = 16'h0000; // No pin locked
  localparam logic [1:0] RESP_OKAY = 2'h0; // Bus answer for a mapped word
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Bus answer for an unmapped word
  // Key sequence states
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00, // Waiting for the first write with key 1
    KEY_SEEN1 = 2'b01, // First write taken
    KEY_SEEN0 = 2'b10, // Second write taken
    KEY_DONE = 2'b11 // Lock engaged
  } key_state_t;
endpackage

// [hdl/pin_field_gate.sv]
// One write-gated 4-bit function selector for a single pin
`timescale 1ns/1ps
module pin_field_gate (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [3:0] strb_mask_i,
  input wire logic locked_i,
  input wire logic [3:0] wdata_i,
  output logic [3:0] sel_o
);
  // Selector is held apart from the top struct so each pin gates itself
  typedef struct packed {
    logic [3:0] sel; // Stored function selector
  } sel_state_t;

  sel_state_t cur; // Registered selector
  sel_state_t next_cur; // Next selector

  // Peripheral reset wins over a write in the same cycle
  always_comb begin
    next_cur = cur;
    if (clr_i) begin
      next_cur.sel = 4'h0;
    end else if (wr_i && !locked_i) begin // [RL11]
      next_cur.sel = (cur.sel & ~strb_mask_i) | (wdata_i & strb_mask_i);
    end
  end

  // Frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else if (ce_i) begin
      cur <= next_cur;
    end
  end

  assign sel_o = cur.sel;
endmodule

// [testbench/port_config_lock_and_altfunc_test.sv]
// Self-checking bench for the port lock and function select block
`timescale 1ns/1ps
module port_config_lock_and_altfunc_test;
  import port_lock_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, periph_rst_i = 0, ce_i = 1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = '0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, lock_key_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, pin_function_select_low_o;
  logic [15:0] pin_lock_o;
  int fails = 0, n_checks = 0, cyc = 0;
  logic [31:0] e_func, rdat; // Expected selectors, last read word
  logic [15:0] e_lk, pat; // Expected lock bits, pattern of open sequence
  logic e_key; // Expected key
  logic [1:0] st, resp; // Sequence progress, last bus answer

  always #2.5 clk_sys_i = ~clk_sys_i;

  port_config_lock_and_altfunc port_config_lock_and_altfunc_i (.clk_sys_i, .rst_n_i, .periph_rst_i, .ce_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pin_lock_o,
    .lock_key_o, .pin_function_select_low_o);

  task automatic close_out;
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are sampled at the falling edge: inputs and registered outputs are settled there
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tb = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
    end while (!tb);
    s_axi_bready_i <= 1'b0;
    // One idle edge so the next call never re-raises bready in this time step
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tr = s_axi_rvalid_o;
      rdat = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
    end while (!tr);
    s_axi_rready_i <= 1'b0;
    // One idle edge so the next call never re-raises rready in this time step
    @(posedge clk_sys_i);
  endtask

  // Byte strobes cover two pins each; a locked pin keeps its selector
  function automatic logic [31:0] f_next(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    f_next = o;
    for (int y = 0; y < FUNC_PINS; y++) begin
      if (s[y/2] && !(e_key && e_lk[y])) f_next[FUNC_WIDTH*y +: FUNC_WIDTH] = n[FUNC_WIDTH*y +: FUNC_WIDTH];
    end
  endfunction

  task automatic m_reset;
    e_func = FUNC_LOW_RESET;
    e_lk = PIN_LOCK_RESET;
    e_key = 1'b0;
    st = 2'd0;
  endtask

  task automatic fw(input logic [31:0] d, input logic [3:0] s);
    wr(OFFS_FUNC_LOW, d, s);
    e_func = f_next(e_func, d, s);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(OFFS_FUNC_LOW);
    chk(rdat, e_func);
    chk(pin_function_select_low_o, e_func);
  endtask

  // Once locked, lock bits and key do not move until a reset
  task automatic lw(input logic k, input logic [15:0] p);
    wr(OFFS_LOCK, {15'h0, k, p}, 4'hf);
    if (!e_key) begin
      e_lk = p;
      if (k && st == 2'd2 && p == pat) e_key = 1'b1;
      else if (k) begin
        st = 2'd1;
        pat = p;
      end
      else st = (st == 2'd1 && p == pat) ? 2'd2 : 2'd0;
    end
    rd(OFFS_LOCK);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    chk(rdat, {15'h0, e_key, e_lk});
    chk({15'h0, lock_key_o, pin_lock_o}, {15'h0, e_key, e_lk});
  endtask

  task automatic mix(input int n);
    repeat (n) begin
      if ($urandom_range(1)) fw($urandom, 4'($urandom));
      else lw(1'($urandom), 16'($urandom));
    end
  endtask

  initial begin
    void'($urandom(27));
    m_reset;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(OFFS_FUNC_LOW);
    chk(rdat, FUNC_LOW_RESET);
    rd(8'h04);
    chk({resp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h40, 32'hffff_ffff, 4'hf);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    fw(32'hfedc_ba98, 4'hf);
    fw(32'h0123_4567, 4'h5);
    mix(20);
    // Changed pattern aborts, the next key-1 write opens a fresh sequence that the last write completes
    lw(1'b1, 16'h00a5);
    lw(1'b0, 16'h005a);
    lw(1'b1, 16'h00a5);
    lw(1'b0, 16'h00a5);
    lw(1'b1, 16'h00a5);
    fw(32'h9999_9999, 4'hf);
    // Clock enable low freezes everything, even a peripheral reset request
    ce_i <= 1'b0;
    periph_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    periph_rst_i <= 1'b0;
    ce_i <= 1'b1;
    @(posedge clk_sys_i);
    lw(1'b0, 16'h00ff);
    mix(20);
    periph_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    periph_rst_i <= 1'b0;
    m_reset;
    rd(OFFS_LOCK);
    chk(rdat, 32'h0);
    rd(OFFS_FUNC_LOW);
    chk(rdat, FUNC_LOW_RESET);
    mix(10);
    close_out;
  end
endmodule
